// ### src/ioxp_regs.vh
// register offsets, reset values and address constants of the i2c port expander
`ifndef IOXP_REGS_VH
`define IOXP_REGS_VH
`define IOXP_ADDR_HI       4'h4
`define IOXP_REG_IN_A      3'h0
`define IOXP_REG_IN_B      3'h1
`define IOXP_REG_OUT_A     3'h2
`define IOXP_REG_OUT_B     3'h3
`define IOXP_REG_INV_A     3'h4
`define IOXP_REG_INV_B     3'h5
`define IOXP_REG_DIR_A     3'h6
`define IOXP_REG_DIR_B     3'h7
`define IOXP_RST_OUT       8'hff
`define IOXP_RST_INV       8'h00
`define IOXP_RST_DIR       8'hff
`define IOXP_SEL_RST       3'h0
`endif

// ### src/ioxp_top.v
// i2c slave register interface and port logic of a 16-bit i/o expander
`timescale 1ns/1ps
`include "ioxp_regs.vh"

// Function
// - address acked, select byte acked, data bytes follow, STOP ends.
// - repeated START stores the register currently accessed as the selection.
// - further read bytes alternate between the two registers of the pair.
// - reads of any length are served while the master acknowledges.
// - written data is stored on the rising edge of its ack clock.
// - STOP may end anywhere; registers already taken stay and drive outputs.
// - slave address is fixed upper bits plus the three address straps.
// - first byte after write address is the selection; low three bits used.
// - selection changes only on a new select byte in a write or on a repeated START.
// - selections 0..7: input levels, output latches, inversion, direction.
// - latches and directions reset to ones, inversion to zeros.
// - input level registers return pin level; writes to them ignored.
// - latch drives output pins only; reading it returns the latch.
// - inversion bit one inverts the reported input level.
// - direction one makes pin an input, zero a driven output.
// - last address bit: one means read, zero means write.
module ioxp_top (
	input  wire        clk,
	input  wire        resetn,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_oe,
	output reg         sda_out,
	input  wire        addr_strap_bit_zero,
	input  wire        addr_strap_bit_one,
	input  wire        addr_strap_bit_two,
	input  wire [7:0]  port_a_pins_in,
	input  wire [7:0]  port_b_pins_in,
	output reg  [7:0]  port_a_pins_out,
	output reg  [7:0]  port_b_pins_out,
	output reg  [7:0]  port_a_pins_oe,
	output reg  [7:0]  port_b_pins_oe
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_SEL  = 3'h2;
	localparam ST_WDAT = 3'h3;
	localparam ST_RDAT = 3'h4;
	localparam ST_MACK = 3'h5;
	localparam ST_SKIP = 3'h6;

	reg        rst_m_q;
	reg        rst_q;
	reg  [1:0] scl_s_q;
	reg  [1:0] sda_s_q;
	reg        scl_q;
	reg        sda_q;
	reg  [2:0] strap_s1_q;
	reg  [2:0] strap_q;
	reg  [7:0] pa_s1_q;
	reg  [7:0] pb_s1_q;
	reg  [7:0] pa_q;
	reg  [7:0] pb_q;
	reg  [2:0] state_q;
	reg  [3:0] bit_q;
	reg  [7:0] shift_q;
	reg        ack_q;
	reg  [2:0] sel_q;
	reg  [2:0] cur_q;
	reg  [7:0] port_a_output_latch_bits;
	reg  [7:0] port_b_output_latch_bits;
	reg  [7:0] port_a_invert_bits;
	reg  [7:0] port_b_invert_bits;
	reg  [7:0] port_a_direction_bits;
	reg  [7:0] port_b_direction_bits;
	// two-entry buffer between captured bytes and the register file
	reg  [10:0] buf_q [0:1];
	reg         buf_wp_q;
	reg         buf_rp_q;
	reg  [1:0]  buf_cnt_q;

	wire scl_rise = scl_s_q[1] & ~scl_q;
	wire scl_fall = ~scl_s_q[1] & scl_q;
	wire start_c  = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
	wire stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
	wire [7:0] port_a_input_level_bits = pa_q ^ port_a_invert_bits;
	wire [7:0] port_b_input_level_bits = pb_q ^ port_b_invert_bits;
	wire [6:0] my_addr = {`IOXP_ADDR_HI, strap_q};
	wire       buf_in_valid;
	wire       buf_in_ready = (buf_cnt_q != 2'h2);
	wire       buf_out_valid = (buf_cnt_q != 2'h0);
	wire       buf_out_ready = 1'b1;
	wire [10:0] buf_head = buf_q[buf_rp_q];
	wire [2:0] sel_bits = {shift_q[2], shift_q[1], shift_q[0]};
	reg  [7:0] rd_byte;

	// reset release through two flops
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_m_q <= 1'b0;
			rst_q   <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_q   <= rst_m_q;
		end
	end

	// synchronisers for the bus, straps and pins
	always @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			scl_s_q    <= 2'h3;
			sda_s_q    <= 2'h3;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			strap_s1_q <= 3'h0;
			strap_q    <= 3'h0;
			pa_s1_q    <= 8'h00;
			pb_s1_q    <= 8'h00;
			pa_q       <= 8'h00;
			pb_q       <= 8'h00;
		end else begin
			scl_s_q    <= {scl_s_q[0], scl_in};
			sda_s_q    <= {sda_s_q[0], sda_in};
			scl_q      <= scl_s_q[1];
			sda_q      <= sda_s_q[1];
			strap_s1_q <= {addr_strap_bit_two, addr_strap_bit_one, addr_strap_bit_zero};
			strap_q    <= strap_s1_q;
			pa_s1_q    <= port_a_pins_in;
			pb_s1_q    <= port_b_pins_in;
			pa_q       <= pa_s1_q;
			pb_q       <= pb_s1_q;
		end
	end

	// byte presented to the master for the current register
	always @* begin
		case (cur_q)
		`IOXP_REG_IN_A:  rd_byte = port_a_input_level_bits;
		`IOXP_REG_IN_B:  rd_byte = port_b_input_level_bits;
		`IOXP_REG_OUT_A: rd_byte = port_a_output_latch_bits;
		`IOXP_REG_OUT_B: rd_byte = port_b_output_latch_bits;
		`IOXP_REG_INV_A: rd_byte = port_a_invert_bits;
		`IOXP_REG_INV_B: rd_byte = port_b_invert_bits;
		`IOXP_REG_DIR_A: rd_byte = port_a_direction_bits;
		default:         rd_byte = port_b_direction_bits;
		endcase
	end

	assign buf_in_valid = (state_q == ST_WDAT) & (bit_q == 4'h8) & scl_rise & buf_in_ready;

	// bus protocol engine
	always @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			state_q <= ST_IDLE;
			bit_q   <= 4'h0;
			shift_q <= 8'h00;
			ack_q   <= 1'b0;
			sel_q   <= `IOXP_SEL_RST;
			cur_q   <= `IOXP_SEL_RST;
			sda_oe  <= 1'b0;
			sda_out <= 1'b0;
		end else if (stop_c) begin
			state_q <= ST_IDLE;
			sda_oe  <= 1'b0;
		end else if (start_c) begin
			if (state_q != ST_IDLE)
				sel_q <= cur_q;
			state_q <= ST_ADDR;
			bit_q   <= 4'h0;
			sda_oe  <= 1'b0;
		end else if (scl_rise && state_q != ST_RDAT) begin // sender shifts on falls only
			if (bit_q < 4'h8) begin
				shift_q <= {shift_q[6:0], sda_q};
				bit_q   <= bit_q + 4'h1;
			end else if (state_q == ST_MACK || state_q == ST_RDAT) begin
				ack_q <= ~sda_q;
				bit_q <= 4'h9;
			end else begin
				bit_q <= 4'h9;
			end
		end else if (scl_fall) begin
			case (state_q)
			ST_ADDR: begin
				if (bit_q == 4'h8) begin
					if (shift_q[7:1] == my_addr) begin
						sda_oe  <= 1'b1;
						sda_out <= 1'b0;
					end else begin
						state_q <= ST_SKIP;
					end
				end else if (bit_q == 4'h9) begin
					bit_q <= 4'h0;
					if (shift_q[0]) begin
						// ack stays one more cycle; first byte loads once cur_q
						// holds the selection, so a stale cur_q is never sent
						state_q <= ST_RDAT;
						cur_q   <= sel_q;
						sda_out <= 1'b0;
					end else begin
						state_q <= ST_SEL;
						sda_oe  <= 1'b0;
					end
				end
			end
			ST_SEL, ST_WDAT: begin
				if (bit_q == 4'h8) begin
					sda_oe  <= 1'b1;
					sda_out <= 1'b0;
					if (state_q == ST_SEL) begin
						sel_q <= sel_bits;
						cur_q <= sel_bits;
					end
				end else if (bit_q == 4'h9) begin
					if (state_q == ST_WDAT)
						cur_q <= {cur_q[2:1], ~cur_q[0]};
					state_q <= ST_WDAT;
					sda_oe  <= 1'b0;
					bit_q   <= 4'h0;
				end
			end
			ST_RDAT: begin
				if (bit_q == 4'h8) begin
					state_q <= ST_MACK;
					sda_oe  <= 1'b0;
				end else begin
					sda_oe  <= ~shift_q[7];
					shift_q <= {shift_q[6:0], 1'b0};
					bit_q   <= bit_q + 4'h1;
				end
			end
			ST_MACK: begin
				if (bit_q == 4'h9) begin
					if (ack_q) begin
						state_q <= ST_RDAT;
						cur_q   <= {cur_q[2:1], ~cur_q[0]};
						bit_q   <= 4'h0;
					end else begin
						state_q <= ST_SKIP;
					end
				end
			end
			ST_SKIP: sda_oe <= 1'b0;
			default: state_q <= ST_IDLE;
			endcase
		end else if (state_q == ST_RDAT && bit_q == 4'h0) begin
			// load the next byte from the register just selected
			sda_oe  <= ~rd_byte[7];
			shift_q <= {rd_byte[6:0], 1'b0};
			bit_q   <= 4'h1;
		end
	end

	// two-entry buffer of {register, data}
	always @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			buf_q[0]  <= 11'h000;
			buf_q[1]  <= 11'h000;
			buf_wp_q  <= 1'b0;
			buf_rp_q  <= 1'b0;
			buf_cnt_q <= 2'h0;
		end else begin
			if (buf_in_valid) begin
				buf_q[buf_wp_q] <= {cur_q, shift_q};
				buf_wp_q <= ~buf_wp_q;
			end
			if (buf_out_valid & buf_out_ready)
				buf_rp_q <= ~buf_rp_q;
			buf_cnt_q <= buf_cnt_q + {1'b0, buf_in_valid}
				- {1'b0, buf_out_valid & buf_out_ready};
		end
	end

	// register file and pin drive
	always @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			port_a_output_latch_bits <= `IOXP_RST_OUT;
			port_b_output_latch_bits <= `IOXP_RST_OUT;
			port_a_invert_bits       <= `IOXP_RST_INV;
			port_b_invert_bits       <= `IOXP_RST_INV;
			port_a_direction_bits    <= `IOXP_RST_DIR;
			port_b_direction_bits    <= `IOXP_RST_DIR;
			port_a_pins_out          <= `IOXP_RST_OUT;
			port_b_pins_out          <= `IOXP_RST_OUT;
			port_a_pins_oe           <= 8'h00;
			port_b_pins_oe           <= 8'h00;
		end else begin
			if (buf_out_valid & buf_out_ready) begin
				case (buf_head[10:8])
				`IOXP_REG_OUT_A: port_a_output_latch_bits <= buf_head[7:0];
				`IOXP_REG_OUT_B: port_b_output_latch_bits <= buf_head[7:0];
				`IOXP_REG_INV_A: port_a_invert_bits <= buf_head[7:0];
				`IOXP_REG_INV_B: port_b_invert_bits <= buf_head[7:0];
				`IOXP_REG_DIR_A: port_a_direction_bits <= buf_head[7:0];
				`IOXP_REG_DIR_B: port_b_direction_bits <= buf_head[7:0];
				default: ;
				endcase
			end
			port_a_pins_out <= port_a_output_latch_bits;
			port_b_pins_out <= port_b_output_latch_bits;
			port_a_pins_oe  <= ~port_a_direction_bits;
			port_b_pins_oe  <= ~port_b_direction_bits;
		end
	end
endmodule

// ### test/ioxp_monitor.sv
// port assertions for the i2c port expander
`timescale 1ns/1ps
module ioxp_monitor (
	input wire       clk,
	input wire       resetn,
	input wire       scl_in,
	input wire       sda_oe,
	input wire       sda_out,
	input wire [7:0] port_a_pins_out,
	input wire [7:0] port_b_pins_out,
	input wire [7:0] port_a_pins_oe,
	input wire [7:0] port_b_pins_oe
);
	// all pin outputs in one word
	wire [31:0] pins = {port_a_pins_out, port_b_pins_out, port_a_pins_oe, port_b_pins_oe};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// quiet bus after reset; a driven bit stands most of an scl period
	sequence seq_quiet;
		(!sda_oe)[*4];
	endsequence
	sequence seq_held;
		sda_oe[*6];
	endsequence
	chk_reset_pins: assert property ($rose(resetn) |-> pins == 32'hffff_0000)
		else $error("pins off reset state");
	chk_reset_quiet: assert property ($rose(resetn) |-> seq_quiet)
		else $error("sda driven after reset");
	chk_sda_drain: assert property (sda_oe |-> !sda_out)
		else $error("sda driven high");
	chk_sda_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
		else $error("sda moved at scl high");
	chk_sda_scl_high: assert property (scl_in && $past(scl_in, 2) |-> $stable(sda_oe))
		else $error("sda moved in scl high");
	chk_bit_held: assert property ($rose(sda_oe) |-> seq_held)
		else $error("driven bit too short");
	chk_pins_at_ack: assert property ($changed(pins) |-> $past(scl_in, 4) || $past(scl_in, 6))
		else $error("pins moved off ack");
	chk_idle_free: assert property (scl_in[*8] |-> !sda_oe)
		else $error("sda held on idle bus");
endmodule
bind ioxp_top ioxp_monitor mon_u (.*);

// ### test/ioxp_i2c_master.sv
// i2c bus master model driving the expander link
`timescale 1ns/1ps
module ioxp_i2c_master (
	output logic scl,
	output logic sda_pull,
	input  wire  sda_bus
);
	// idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// start or repeated start: sda falls while scl is high
	task automatic go_start();
		#100 sda_pull = 1'b0;
		#300 scl = 1'b1;
		#400 sda_pull = 1'b1;
		#400 scl = 1'b0;
	endtask
	// stop: sda rises while scl is high
	task automatic go_stop();
		#100 sda_pull = 1'b1;
		#300 scl = 1'b1;
		#400 sda_pull = 1'b0;
	endtask
	// one bit: data moves in scl low, sampled mid high
	task automatic bit_io(input logic b, output logic r);
		#100 sda_pull = !b;
		#300 scl = 1'b1;
		#200 r = sda_bus;
		#200 scl = 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// line released for data; ack all but the last byte
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// ### test/ioxp_top_bench.sv
// self-checking bench for the i2c port expander
`timescale 1ns/1ps
module ioxp_top_bench;
	localparam logic [6:0] A = 7'h25;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	int         mismatches = 0;
	int         checks_done = 0;
	int         cyc = 0;
	wire        scl, sda_pull, sda_oe, sda_out;
	wire  [7:0] pa_out, pb_out, pa_oe, pb_oe;
	// pulled-up sda; a pin shows its driver where enabled
	wire        sda = !(sda_pull || (sda_oe && !sda_out));
	wire  [7:0] pa_in = (pa_oe & pa_out) | (~pa_oe & 8'h96);
	wire  [7:0] pb_in = (pb_oe & pb_out) | (~pb_oe & 8'h12);
	always #50 clk = ~clk;
	ioxp_i2c_master m_u (.scl(scl), .sda_pull(sda_pull), .sda_bus(sda));
	ioxp_top dut_u (
		.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
		.sda_oe(sda_oe), .sda_out(sda_out), .addr_strap_bit_zero(1'b1),
		.addr_strap_bit_one(1'b0), .addr_strap_bit_two(1'b1),
		.port_a_pins_in(pa_in), .port_b_pins_in(pb_in),
		.port_a_pins_out(pa_out), .port_b_pins_out(pb_out),
		.port_a_pins_oe(pa_oe), .port_b_pins_oe(pb_oe)
	);
	task automatic end_sim();
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] d, input logic ack_exp);
		logic a;
		m_u.put_byte(d, a);
		chk({7'h0, a}, {7'h0, ack_exp});
	endtask
	// select (skipped if above 7), repeated start, read n bytes
	task automatic rd(input logic [7:0] sel, input logic [23:0] exp, input int n);
		logic [7:0] b;
		if (sel < 8) begin
			m_u.go_start();
			put({A, 1'b0}, 1'b1);
			put(sel, 1'b1);
		end
		m_u.go_start();
		put({A, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) begin
			m_u.get_byte(i == n - 1, b);
			chk(b, exp[23 - 8 * i -: 8]);
		end
		m_u.go_stop();
	endtask
	task automatic wr(input logic [7:0] sel, input logic [15:0] d, input int n);
		m_u.go_start();
		put({A, 1'b0}, 1'b1);
		put(sel, 1'b1);
		for (int i = 0; i < n; i++) put(d[15 - 8 * i -: 8], 1'b1);
		m_u.go_stop();
	endtask
	// every selection code read from reset
	task automatic t_reset();
		logic [7:0] v [8] = '{8'h96, 8'h12, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
		for (int s = 0; s < 8; s++) rd(8'(s), {v[s], v[s ^ 1], v[s]}, 3);
	endtask
	// direction and latch writes reach the pins; stop after one byte
	task automatic t_write();
		wr(8'h06, 16'h0fa5, 2);
		wr(8'h02, 16'h3cc3, 2);
		chk(pa_oe, 8'hf0);
		chk(pb_oe, 8'h5a);
		rd(8'h03, 24'hc33cc3, 3);
		wr(8'h02, 16'h7e00, 1);
		chk(pa_out, 8'h7e);
		chk(pb_out, 8'hc3);
		// restart after one data byte keeps the register then in use
		m_u.go_start();
		put({A, 1'b0}, 1'b1);
		put(8'h02, 1'b1);
		put(8'h7e, 1'b1);
		rd(8'hff, 24'hc37ec3, 2);
		rd(8'hff, 24'hc37ec3, 2);
	endtask
	// inversion, ignored input writes, selection kept
	task automatic t_input();
		wr(8'h04, 16'hff81, 2);
		wr(8'h00, 16'h5555, 2);
		rd(8'h00, 24'h89c389, 3);
		rd(8'hff, 24'h89c389, 2);
	endtask
	// neighbouring addresses get no ack
	task automatic t_refuse();
		m_u.go_start();
		put(8'h4c, 1'b0);
		m_u.go_start();
		put(8'h48, 1'b0);
		m_u.go_stop();
		rd(8'h05, 24'h81ff81, 3);
	endtask
	// cycle ceiling against a hung bus
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			end_sim();
		end
	end
	// reset, then the scenarios
	initial begin
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (8) @(posedge clk);
		#1;
		t_reset();
		t_write();
		t_input();
		t_refuse();
		end_sim();
	end
endmodule
